// ==== common/rvr_pkg.sv ====
// package: register map, reset values, field layouts and protocol states
package rvr_pkg;
    // register indices
    localparam logic [7:0] IDX_VOLT_CODE  = 8'h00;
    localparam logic [7:0] IDX_LOAD_CUR   = 8'h03;
    localparam logic [7:0] IDX_CEILING    = 8'h04;
    localparam logic [7:0] IDX_PHASE_MODE = 8'h06;
    localparam logic [7:0] IDX_SLEW       = 8'h07;
    localparam logic [7:0] IDX_LOT_FIRST  = 8'h10;
    localparam logic [7:0] IDX_LOT_LAST   = 8'h13;
    localparam logic [7:0] IDX_FAULT      = 8'h14;
    // field positions
    localparam int CEIL_LOCK_BIT = 7;
    localparam int FLT_THERMAL   = 3;
    localparam int FLT_OVERVOLT  = 2;
    localparam int FLT_UNDERVOLT = 1;
    localparam int FLT_OVERCUR   = 0;
    // reset values and limits
    localparam logic [6:0] BOOT_CODE_RST  = 7'h37;
    localparam logic [6:0] VOLT_CODE_MIN  = 7'h19;
    localparam logic [6:0] CEILING_RST    = 7'h7f;
    localparam logic [1:0] PHASE_MODE_RST = 2'h0;
    localparam logic [1:0] PHASE_MODE_MAX = 2'h2;
    localparam logic [7:0] LOAD_CUR_RST   = 8'h00;
    localparam logic [3:0] FAULT_RST      = 4'h0;
    // bus address: fixed upper bits, strap supplies the rest
    localparam logic [3:0] DEV_ADDR_HI    = 4'h8;
    // strap decode in millivolts: zero band limit, then band pitch
    localparam int STRAP_ZERO_MV  = 300;
    localparam int STRAP_PITCH_MV = 200;
    localparam int STRAP_CODES    = 8;

    // phase and conduction modes
    localparam logic [1:0] MODE_MULTI_CONT  = 2'h0;
    localparam logic [1:0] MODE_SINGLE_CONT = 2'h1;
    localparam logic [1:0] MODE_SINGLE_DISC = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_IDX, ST_IDX_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_IGNORE
    } rvr_bus_state_t;

    // software-visible register bank
    typedef struct packed {
        logic [6:0] volt_code;
        logic       ceil_lock;
        logic [6:0] ceiling;
        logic [1:0] phase_mode;
        logic [7:0] slew_sel;
        logic [7:0] load_cur;
        logic [3:0] faults;
    } rvr_regs_t;

    // fault inputs as one group
    typedef struct packed {
        logic thermal;
        logic overvoltage_fault;
        logic undervoltage_fault;
        logic overcurrent;
    } rvr_fault_t;
endpackage : rvr_pkg

// ==== hdl/rvr_i2c_regs.sv ====
// regulator register bank behind a byte-oriented two-wire slave port
//
// Functional notes
// - Answers address 1000xxx; low three bits captured from strap at start-up.
// - Only single-byte read and single-byte write; extra bytes are not acknowledged.
// - Serial clock oversampled; works from 100 kHz up to 3.4 MHz.
// - Register port stays fully usable while converter enable is low.
// - Read: address+write, index, repeated start, address+read, one byte, master NAK.
// - Read aimed at a missing index gets its index byte not acknowledged.
// - Write aimed at a missing index gets index NAK and stores nothing.
// - Write with a forbidden value gets data NAK; register unchanged.
// - Voltage code at 00h, bits 6:0, boot value at power-up, kept on enable rise.
// - Voltage code write below 19h gets NAK, old code kept.
// - Load-current reading at 03h, read-only, 00h at power-up and enable rise.
// - Ceiling at 04h bits 6:0, 7Fh at power-up, kept across enable rises.
// - Ceiling bit 7 locks the register until a supply lockout event.
// - Phase mode at 06h bits 1:0; cleared at power-up and enable rise.
// - Slew at 07h one-hot 6..48 mV/us, strap at power-up, kept on enable rise.
// - Start-up ramp uses half of the selected slew rate.
// - Indices 10h..13h are fixed read-only lot code bytes.
// - Fault flags at 14h read-only, 00h at power-up: thermal, over, under, current.
// - Strap selects one of eight addresses; code 0 means address 40h.
// - Strap up to 0.30 V gives 0; 0.2 V bands centred 0.4..1.6 V give 1..7.
// - Reading FFh stands for full-scale load current.
`timescale 1ns/1ps
`default_nettype none

module rvr_i2c_regs #(
    parameter logic [6:0]  BOOT_CODE = rvr_pkg::BOOT_CODE_RST,
    parameter logic [31:0] LOT_CODE  = 32'h0000_0000  // arbitrary value
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_o,
    input  wire logic              en_i,
    input  wire logic [10:0]       strap_mv_i,
    input  wire logic [2:0]        slew_strap_sel_i,
    input  wire logic              supply_lockout_event_i,
    input  wire logic              startup_ramp_i,
    input  wire logic [7:0]        load_current_reading_i,
    input  wire rvr_pkg::rvr_fault_t fault_i,
    output logic [6:0]             output_voltage_code_o,
    output logic [6:0]             voltage_code_ceiling_o,
    output logic                   ceiling_lock_o,
    output logic [1:0]             phase_mode_o,
    output logic [7:0]             slew_rate_select_o,
    output logic [4:0]             slew_step_3mv_o,
    output logic [6:0]             dev_addr_o
);

    typedef struct packed {
        logic                    scl_m;
        logic                    scl_s;
        logic                    scl_p;
        logic                    sda_m;
        logic                    sda_s;
        logic                    sda_p;
        logic                    en_m;
        logic                    en_s;
        logic                    en_p;
        rvr_pkg::rvr_bus_state_t st;
        logic [3:0]              bit_cnt;
        logic [7:0]              shreg;
        logic                    rd;
        logic [7:0]              idx;
        logic                    sda_oe;
        logic                    strap_done;
        logic [2:0]              addr_lo;
        rvr_pkg::rvr_regs_t      regs;
        logic [4:0]              slew_step;
    } rvr_state_t;

    rvr_state_t s_r;
    rvr_state_t s_nxt;

    // strap millivolts to low address bits
    function automatic logic [2:0] strap_decode(input logic [10:0] mv);
        logic [2:0] code;
        code = 3'h0;
        for (int i = 1; i < rvr_pkg::STRAP_CODES; i++) begin
            if (int'(mv) > rvr_pkg::STRAP_ZERO_MV + rvr_pkg::STRAP_PITCH_MV * (i - 1)) begin
                code = 3'(i);
            end
        end
        return code;
    endfunction : strap_decode

    // index exists in the map
    function automatic logic idx_valid(input logic [7:0] idx);
        return (idx == rvr_pkg::IDX_VOLT_CODE) || (idx == rvr_pkg::IDX_LOAD_CUR) ||
               (idx == rvr_pkg::IDX_CEILING) || (idx == rvr_pkg::IDX_PHASE_MODE) ||
               (idx == rvr_pkg::IDX_SLEW) || (idx == rvr_pkg::IDX_FAULT) ||
               ((idx >= rvr_pkg::IDX_LOT_FIRST) && (idx <= rvr_pkg::IDX_LOT_LAST));
    endfunction : idx_valid

    // write data acceptable for the addressed register
    function automatic logic wr_allowed(input logic [7:0] idx, input logic [7:0] d,
                                        input rvr_pkg::rvr_regs_t r);
        logic ok;
        ok = 1'b0;
        if (idx == rvr_pkg::IDX_VOLT_CODE) begin
            ok = (d[6:0] >= rvr_pkg::VOLT_CODE_MIN);
        end else if (idx == rvr_pkg::IDX_CEILING) begin
            ok = !r.ceil_lock;
        end else if (idx == rvr_pkg::IDX_PHASE_MODE) begin
            ok = (d <= {6'h00, rvr_pkg::PHASE_MODE_MAX});
        end else if (idx == rvr_pkg::IDX_SLEW) begin
            ok = (d != 8'h00) && ((d & (d - 8'h01)) == 8'h00);
        end
        return ok; // read-only registers refuse data
    endfunction : wr_allowed

    // read data for an index
    function automatic logic [7:0] rd_mux(input logic [7:0] idx, input rvr_pkg::rvr_regs_t r);
        logic [7:0] d;
        d = 8'h00;
        if (idx == rvr_pkg::IDX_VOLT_CODE) begin
            d = {1'b0, r.volt_code};
        end else if (idx == rvr_pkg::IDX_LOAD_CUR) begin
            d = r.load_cur;
        end else if (idx == rvr_pkg::IDX_CEILING) begin
            d = {r.ceil_lock, r.ceiling};
        end else if (idx == rvr_pkg::IDX_PHASE_MODE) begin
            d = {6'h00, r.phase_mode};
        end else if (idx == rvr_pkg::IDX_SLEW) begin
            d = r.slew_sel;
        end else if ((idx >= rvr_pkg::IDX_LOT_FIRST) && (idx <= rvr_pkg::IDX_LOT_LAST)) begin
            d = LOT_CODE[8 * (idx - rvr_pkg::IDX_LOT_FIRST) +: 8];
        end else if (idx == rvr_pkg::IDX_FAULT) begin
            d = {4'h0, r.faults};
        end
        return d;
    endfunction : rd_mux

    // one-hot slew select to rate index plus one, in 6 mV/us units
    function automatic logic [4:0] slew_units(input logic [7:0] sel);
        logic [4:0] u;
        u = 5'h00;
        for (int i = 0; i < 8; i++) begin
            if (sel[i]) begin
                u = 5'(i + 1);
            end
        end
        return u;
    endfunction : slew_units

    // next-state logic: sync, bus protocol, register bank
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic [7:0] rx;
        s_nxt    = s_r;
        scl_rise = s_r.scl_s && !s_r.scl_p;
        scl_fall = !s_r.scl_s && s_r.scl_p;
        start_c  = s_r.scl_s && s_r.scl_p && s_r.sda_p && !s_r.sda_s;
        stop_c   = s_r.scl_s && s_r.scl_p && !s_r.sda_p && s_r.sda_s;
        rx       = {s_r.shreg[6:0], s_r.sda_s};

        // two-stage synchronisers, then edge history
        s_nxt.scl_m = scl_i;
        s_nxt.scl_s = s_r.scl_m;
        s_nxt.scl_p = s_r.scl_s;
        s_nxt.sda_m = sda_i;
        s_nxt.sda_s = s_r.sda_m;
        s_nxt.sda_p = s_r.sda_s;
        s_nxt.en_m  = en_i;
        s_nxt.en_s  = s_r.en_m;
        s_nxt.en_p  = s_r.en_s;

        // strap capture once after reset release
        if (!s_r.strap_done) begin
            s_nxt.strap_done    = 1'b1;
            s_nxt.addr_lo       = strap_decode(strap_mv_i);
            s_nxt.regs.slew_sel = 8'h01 << slew_strap_sel_i;
        end

        // byte protocol, independent of enable
        case (s_r.st)
            rvr_pkg::ST_ADDR, rvr_pkg::ST_IDX, rvr_pkg::ST_WDATA: begin
                if (scl_rise) begin
                    s_nxt.shreg   = rx;
                    s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                end else if (scl_fall && (s_r.bit_cnt == 4'h8)) begin
                    s_nxt.bit_cnt = 4'h0;
                    if (s_r.st == rvr_pkg::ST_ADDR) begin
                        if (s_r.shreg[7:1] == {rvr_pkg::DEV_ADDR_HI, s_r.addr_lo}) begin
                            s_nxt.rd     = s_r.shreg[0];
                            s_nxt.sda_oe = 1'b1;
                            s_nxt.st     = rvr_pkg::ST_ADDR_ACK;
                        end else begin
                            s_nxt.st = rvr_pkg::ST_IDLE;
                        end
                    end else if (s_r.st == rvr_pkg::ST_IDX) begin
                        s_nxt.idx = s_r.shreg;
                        if (idx_valid(s_r.shreg)) begin
                            s_nxt.sda_oe = 1'b1;
                            s_nxt.st     = rvr_pkg::ST_IDX_ACK;
                        end else begin
                            s_nxt.st = rvr_pkg::ST_IGNORE;
                        end
                    end else if (wr_allowed(s_r.idx, s_r.shreg, s_r.regs)) begin
                        s_nxt.sda_oe = 1'b1;
                        s_nxt.st     = rvr_pkg::ST_WDATA_ACK;
                        if (s_r.idx == rvr_pkg::IDX_VOLT_CODE) begin
                            s_nxt.regs.volt_code = s_r.shreg[6:0];
                        end else if (s_r.idx == rvr_pkg::IDX_CEILING) begin
                            s_nxt.regs.ceil_lock = s_r.shreg[rvr_pkg::CEIL_LOCK_BIT];
                            s_nxt.regs.ceiling   = s_r.shreg[6:0];
                        end else if (s_r.idx == rvr_pkg::IDX_PHASE_MODE) begin
                            s_nxt.regs.phase_mode = s_r.shreg[1:0];
                        end else begin
                            s_nxt.regs.slew_sel = s_r.shreg;
                        end
                    end else begin
                        s_nxt.st = rvr_pkg::ST_IGNORE;
                    end
                end
            end
            rvr_pkg::ST_ADDR_ACK: begin
                if (scl_fall) begin
                    if (s_r.rd) begin
                        s_nxt.shreg  = rd_mux(s_r.idx, s_r.regs);
                        s_nxt.sda_oe = !s_nxt.shreg[7]; // msb first, pull low for a zero
                        s_nxt.st     = rvr_pkg::ST_RDATA;
                    end else begin
                        s_nxt.sda_oe = 1'b0;
                        s_nxt.st     = rvr_pkg::ST_IDX;
                    end
                end
            end
            rvr_pkg::ST_IDX_ACK: begin
                if (scl_fall) begin
                    s_nxt.sda_oe = 1'b0;
                    s_nxt.st     = rvr_pkg::ST_WDATA; // data byte or repeated start
                end
            end
            rvr_pkg::ST_WDATA_ACK: begin
                if (scl_fall) begin
                    s_nxt.sda_oe = 1'b0;
                    s_nxt.st     = rvr_pkg::ST_IGNORE;
                end
            end
            rvr_pkg::ST_RDATA: begin
                if (scl_fall) begin
                    s_nxt.shreg   = {s_r.shreg[6:0], 1'b0};
                    s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                    if (s_r.bit_cnt == 4'h7) begin
                        s_nxt.bit_cnt = 4'h0;
                        s_nxt.sda_oe  = 1'b0; // release for master NAK
                        s_nxt.st      = rvr_pkg::ST_RACK;
                    end else begin
                        s_nxt.sda_oe = !s_r.shreg[6]; // open drain: drive only zeros
                    end
                end
            end
            rvr_pkg::ST_RACK: begin
                if (scl_rise) begin
                    s_nxt.st = rvr_pkg::ST_IGNORE; // one byte only
                end
            end
            default: begin
                s_nxt.st = s_r.st; // idle or ignoring until start/stop
            end
        endcase

        // start and stop override any byte state
        if (start_c) begin
            s_nxt.st      = rvr_pkg::ST_ADDR;
            s_nxt.bit_cnt = 4'h0;
            s_nxt.sda_oe  = 1'b0;
        end else if (stop_c) begin
            s_nxt.st      = rvr_pkg::ST_IDLE;
            s_nxt.sda_oe  = 1'b0;
        end

        // load current follows the monitor while enabled, fault flags follow at all times
        if (s_r.en_s) begin
            s_nxt.regs.load_cur = load_current_reading_i;
        end
        s_nxt.regs.faults = fault_i;

        // enable rise clears mode and load current, keeps code, ceiling, slew
        if (s_r.en_s && !s_r.en_p) begin
            s_nxt.regs.phase_mode = rvr_pkg::PHASE_MODE_RST;
            s_nxt.regs.load_cur   = rvr_pkg::LOAD_CUR_RST;
        end

        // supply lockout releases the ceiling lock
        if (supply_lockout_event_i) begin
            s_nxt.regs.ceil_lock = 1'b0;
        end

        // ramp rate: half rate during start-up, units of 3 mV/us
        if (startup_ramp_i) begin
            s_nxt.slew_step = slew_units(s_r.regs.slew_sel);
        end else begin
            s_nxt.slew_step = 5'(slew_units(s_r.regs.slew_sel) << 1);
        end
    end

    // state register with power-up values
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r                 <= '0;
            s_r.scl_m           <= 1'b1;
            s_r.scl_s           <= 1'b1;
            s_r.scl_p           <= 1'b1;
            s_r.sda_m           <= 1'b1;
            s_r.sda_s           <= 1'b1;
            s_r.sda_p           <= 1'b1;
            s_r.st              <= rvr_pkg::ST_IDLE;
            s_r.regs.volt_code  <= BOOT_CODE;
            s_r.regs.ceiling    <= rvr_pkg::CEILING_RST;
            s_r.regs.phase_mode <= rvr_pkg::PHASE_MODE_RST;
            s_r.regs.load_cur   <= rvr_pkg::LOAD_CUR_RST;
            s_r.regs.faults     <= rvr_pkg::FAULT_RST;
            s_r.regs.slew_sel   <= 8'h01;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register; sda_o is tied low
    assign sda_o                  = 1'b0;
    assign sda_oe_o               = s_r.sda_oe;
    assign output_voltage_code_o  = s_r.regs.volt_code;
    assign voltage_code_ceiling_o = s_r.regs.ceiling;
    assign ceiling_lock_o         = s_r.regs.ceil_lock;
    assign phase_mode_o           = s_r.regs.phase_mode;
    assign slew_rate_select_o     = s_r.regs.slew_sel;
    assign slew_step_3mv_o        = s_r.slew_step;
    assign dev_addr_o             = {rvr_pkg::DEV_ADDR_HI, s_r.addr_lo};

endmodule : rvr_i2c_regs

`default_nettype wire

// ==== testbench/rvr_i2c_master.sv ====
// bus master model: open-drain two-wire byte transfers
`timescale 1ns/1ps
`default_nettype none
module rvr_i2c_master (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // idle bus: both lines released, pulled high
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    // start or repeated start: data falls while clock is high
    task automatic start();
        tick(2);
        sda_low_o <= 1'b0;
        tick(6);
        scl_o <= 1'b1;
        tick(6);
        sda_low_o <= 1'b1;
        tick(6);
        scl_o <= 1'b0;
    endtask : start
    // stop: data rises while clock is high
    task automatic stop();
        tick(2);
        sda_low_o <= 1'b1;
        tick(6);
        scl_o <= 1'b1;
        tick(6);
        sda_low_o <= 1'b0;
        tick(8);
    endtask : stop
    // one bit: data set mid-low, sampled late in the high phase
    task automatic bit_xfer(input logic b, output logic r);
        tick(2);
        sda_low_o <= ~b;
        tick(2);
        scl_o <= 1'b1;
        tick(3);
        r = sda_i;
        tick(1);
        scl_o <= 1'b0;
    endtask : bit_xfer
    // msb first, ninth bit released by the master
    task automatic xfer_byte(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
            q[i] = r;
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask : xfer_byte
    // single-byte write, acks: address, index, data
    task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d,
                      output logic [2:0] ack);
        logic [7:0] q;
        start();
        xfer_byte({a, 1'b0}, q, ack[2]);
        xfer_byte(idx, q, ack[1]);
        xfer_byte(d, q, ack[0]);
        stop();
    endtask : wr
    // index, repeated start, one byte back, closing nak
    task automatic rd(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] q,
                      output logic [2:0] ack);
        logic n;
        ack[0] = 1'b0;
        start();
        xfer_byte({a, 1'b0}, q, ack[2]);
        xfer_byte(idx, q, ack[1]);
        if (ack[1]) begin
            start();
            xfer_byte({a, 1'b1}, q, ack[0]);
            xfer_byte(8'hff, q, n);
        end
        stop();
    endtask : rd
endmodule : rvr_i2c_master
`default_nettype wire

// ==== testbench/rvr_i2c_regs_props.sv ====
// checker: register port output relations
`timescale 1ns/1ps
`default_nettype none
module rvr_i2c_regs_props (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       en_i,
    input  wire logic       supply_lockout_event_i,
    input  wire logic       startup_ramp_i,
    input  wire logic       sda_oe_o,
    input  wire logic [6:0] output_voltage_code_o,
    input  wire logic [6:0] voltage_code_ceiling_o,
    input  wire logic       ceiling_lock_o,
    input  wire logic [1:0] phase_mode_o,
    input  wire logic [7:0] slew_rate_select_o,
    input  wire logic [4:0] slew_step_3mv_o,
    input  wire logic [6:0] dev_addr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [4:0] step_exp;
    // effective slew from the one-hot select, halved during start-up
    always_comb begin
        step_exp = 5'h0;
        for (int i = 0; i < 8; i++)
            if (slew_rate_select_o[i]) step_exp = startup_ramp_i ? 5'(i + 1) : 5'(2 * i + 2);
    end
    addr_hi_a: assert property (dev_addr_o[6:3] == 4'h8)
        else $error("address upper bits wrong");
    code_min_a: assert property (output_voltage_code_o >= 7'h19)
        else $error("voltage code below minimum");
    mode_range_a: assert property (phase_mode_o <= 2'h2)
        else $error("phase mode out of range");
    slew_onehot_a: assert property ($onehot(slew_rate_select_o))
        else $error("slew select not one-hot");
    lock_hold_a: assert property (ceiling_lock_o && !supply_lockout_event_i |=>
        ceiling_lock_o && $stable(voltage_code_ceiling_o)) else $error("locked ceiling changed");
    lockout_clr_a: assert property (supply_lockout_event_i |=> !ceiling_lock_o)
        else $error("lockout left lock set");
    en_mode_a: assert property ($rose(en_i) |-> ##[1:6] phase_mode_o == 2'h0)
        else $error("enable rise kept phase mode");
    en_keep_a: assert property ($rose(en_i) |=>
        ($stable(output_voltage_code_o) && $stable(voltage_code_ceiling_o)) [*6])
        else $error("enable rise changed code or ceiling");
    step_a: assert property (!$past(rst_i) && $stable(slew_rate_select_o)
        && $stable(startup_ramp_i) |-> slew_step_3mv_o == step_exp) else $error("slew step wrong");
    cover property ($rose(ceiling_lock_o));
    cover property ($fell(ceiling_lock_o));
    cover property ($rose(sda_oe_o));
endmodule : rvr_i2c_regs_props
bind rvr_i2c_regs rvr_i2c_regs_props u_props (.clk_i(clk_i), .rst_i(rst_i), .en_i(en_i),
    .supply_lockout_event_i(supply_lockout_event_i), .startup_ramp_i(startup_ramp_i),
    .sda_oe_o(sda_oe_o), .output_voltage_code_o(output_voltage_code_o),
    .voltage_code_ceiling_o(voltage_code_ceiling_o), .ceiling_lock_o(ceiling_lock_o),
    .phase_mode_o(phase_mode_o), .slew_rate_select_o(slew_rate_select_o),
    .slew_step_3mv_o(slew_step_3mv_o), .dev_addr_o(dev_addr_o));
`default_nettype wire

// ==== testbench/rvr_i2c_regs_tb_top.sv ====
// testbench top: register port scenarios through the bus master model
`timescale 1ns/1ps
`default_nettype none
module rvr_i2c_regs_tb_top;
    localparam logic [6:0] ADDR = 7'h45;  // strap of 1200 mV gives code 5
    logic                clk_i = 1'b0;
    logic                rst_i = 1'b1;
    logic                en_i = 1'b0;
    logic                lockout = 1'b0;
    logic                ramp = 1'b0;
    logic [7:0]          load = 8'hff;
    logic [10:0]         strap_mv = 11'h4b0;
    logic [2:0]          strap_sel = 3'h3;
    rvr_pkg::rvr_fault_t flt = 4'ha;
    logic                scl, m_low, sda_o, sda_oe, lock;
    logic [6:0]          code, ceil, dev_addr;
    logic [1:0]          mode;
    logic [7:0]          slew, q;
    logic [4:0]          step;
    logic [2:0]          ack;
    int                  num_errors = 0;
    int                  cmp_count = 0;
    wire                 sda = ~(m_low | sda_oe);  // pulled up when nobody pulls low
    always #12.5 clk_i = ~clk_i;
    rvr_i2c_master m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
    rvr_i2c_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .en_i(en_i), .strap_mv_i(strap_mv), .slew_strap_sel_i(strap_sel),
        .supply_lockout_event_i(lockout), .startup_ramp_i(ramp), .load_current_reading_i(load),
        .fault_i(flt), .output_voltage_code_o(code), .voltage_code_ceiling_o(ceil),
        .ceiling_lock_o(lock), .phase_mode_o(mode), .slew_rate_select_o(slew),
        .slew_step_3mv_o(step), .dev_addr_o(dev_addr));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // write at our address and compare the three acks
    task automatic w(input logic [7:0] idx, input logic [7:0] d, input logic [2:0] e);
        m.wr(ADDR, idx, d, ack);
        check(ack, e);
    endtask : w
    // power-up values read back with enable low
    task automatic t_reset();
        logic [7:0] ix [10] = '{8'h00, 8'h03, 8'h04, 8'h06, 8'h07, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
        logic [7:0] ex [10] = '{8'h37, 8'h00, 8'h7f, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0a};
        check(dev_addr, 8'h45);
        for (int i = 0; i < 10; i++) begin
            m.rd(ADDR, ix[i], q, ack);
            check(ack, 3'h7);
            check(q, ex[i]);
        end
    endtask : t_reset
    // minimum code boundary and ignored top bit
    task automatic t_volt();
        w(8'h00, 8'h18, 3'h6);
        check(code, 8'h37);
        w(8'h00, 8'h19, 3'h7);
        check(code, 8'h19);
        w(8'h00, 8'hc5, 3'h7);
        m.rd(ADDR, 8'h00, q, ack);
        check(q, 8'h45);
    endtask : t_volt
    // missing indices, read-only targets, foreign address
    task automatic t_index();
        w(8'h05, 8'h40, 3'h4);
        w(8'h03, 8'h11, 3'h6);
        w(8'h13, 8'h11, 3'h6);
        w(8'h14, 8'h11, 3'h6);
        m.rd(ADDR, 8'h15, q, ack);
        check(ack, 3'h4);
        m.wr(7'h40, 8'h00, 8'h30, ack);
        check(ack, 3'h0);
        check(code, 8'h45);
    endtask : t_index
    // every phase mode, bad values, slew one-hot and start-up halving
    task automatic t_modes();
        for (int v = 0; v < 3; v++) begin
            w(8'h06, 8'(v), 3'h7);
            check(mode, 8'(v));
        end
        w(8'h06, 8'h03, 3'h6);
        check(mode, 8'h02);
        w(8'h07, 8'h03, 3'h6);
        w(8'h07, 8'h00, 3'h6);
        w(8'h07, 8'h80, 3'h7);
        check(slew, 8'h80);
        check(step, 8'h10);
        @(posedge clk_i) ramp <= 1'b1;
        m.tick(3);
        check(step, 8'h08);
        ramp <= 1'b0;
    endtask : t_modes
    // lock, refused write while locked, lockout release
    task automatic t_ceiling();
        w(8'h04, 8'ha0, 3'h7);
        check({lock, ceil}, 8'ha0);
        w(8'h04, 8'h10, 3'h6);
        check({lock, ceil}, 8'ha0);
        @(posedge clk_i) lockout <= 1'b1;
        @(posedge clk_i) lockout <= 1'b0;
        m.tick(2);
        check(lock, 8'h00);
        w(8'h04, 8'h6e, 3'h7);
        check({lock, ceil}, 8'h6e);
    endtask : t_ceiling
    // enable rise clears mode, keeps code, ceiling and slew, telemetry follows
    task automatic t_enable();
        w(8'h06, 8'h01, 3'h7);
        @(posedge clk_i) en_i <= 1'b1;
        m.tick(10);
        check(mode, 8'h00);
        check(code, 8'h45);
        check(ceil, 8'h6e);
        check(slew, 8'h80);
        m.rd(ADDR, 8'h03, q, ack);
        check(q, 8'hff);
        load <= 8'h5c;
        flt  <= 4'h5;
        m.rd(ADDR, 8'h03, q, ack);
        check(q, 8'h5c);
        m.rd(ADDR, 8'h14, q, ack);
        check(q, 8'h05);
    endtask : t_enable
    // mid-run power-up with open strap: address 40h, boot values back
    task automatic t_strap();
        rst_i     <= 1'b1;
        strap_mv  <= 11'h000;
        strap_sel <= 3'h0;
        m.tick(5);
        rst_i <= 1'b0;
        m.tick(6);
        check(dev_addr, 8'h40);
        check(slew, 8'h01);
        check(sda_o, 8'h00);
        m.rd(7'h40, 8'h04, q, ack);
        check(q, 8'h7f);
        check(code, 8'h37);
    endtask : t_strap
    // an extra byte after the data byte is refused
    task automatic t_multi();
        m.start();
        m.xfer_byte({ADDR, 1'b0}, q, ack[2]);
        m.xfer_byte(8'h06, q, ack[1]);
        m.xfer_byte(8'h02, q, ack[0]);
        check(ack, 3'h7);
        m.xfer_byte(8'h01, q, ack[0]);
        m.stop();
        check(ack, 3'h6);
        check(mode, 8'h02);
    endtask : t_multi
    // main sequence
    initial begin
        m.tick(5);
        rst_i <= 1'b0;
        m.tick(6);
        t_reset();
        t_volt();
        t_index();
        t_modes();
        t_ceiling();
        t_enable();
        t_multi();
        t_strap();
        complete_run();
    end
    // hang guard
    initial begin
        #2000000;
        num_errors++;
        complete_run();
    end
endmodule : rvr_i2c_regs_tb_top
`default_nettype wire
